// ---- hw/fifo_status_timestamp_irq_cfg.v ----
// fifo status flags, free-running timestamp and interrupt configuration
// assumes fifo level, watermark, batch threshold, trim and event inputs come
// from logic on the same 50 MHz clock; host accesses arrive as one-cycle strobes
//
// Operation
// - level mark set while fill reaches watermark
// - overrun flag high while fifo completely full
// - nearly-full flag one sample ahead of full
// - batch flag set at threshold, read clears
// - sticky overrun flag cleared by status read
// - unread count upper two bits in status
// - all flags and count reset to zero
// - 32-bit read-only timestamp, 25 us tick
// - tick period trimmed by 0.0015 per step
// - latched irq release per clear-upon-read bit
// - sleep output pulse or level when routed
// - filter select slope or high-pass
// - latch mode holds irq until cleared
// - inactivity mode decodes power actions
// - enable bit gates all event functions
// - low eight count bits at 3ah
`default_nettype none
`include "sensor_status_consts.vh"

module fifo_status_timestamp_irq_cfg
  #(parameter FIFO_DEPTH     = 438,  // entries the fifo can hold
    parameter SAMPLE_ENTRIES = 1,    // entries added per sample period
    parameter EVENTS         = 4)    // number of event interrupt lines
  (
    // clock and reset
    input  wire               I_CLK_SYS,
    input  wire               I_RST_B,
    // host register port
    input  wire [7:0]         I_REG_ADDR,
    input  wire               I_REG_WR,
    input  wire [7:0]         I_REG_WDATA,
    input  wire               I_REG_RD,
    output reg  [7:0]         O_REG_RDATA,
    output reg                O_REG_RVALID,
    // fifo and batch counter side
    input  wire [9:0]         I_FIFO_LEVEL,
    input  wire [8:0]         I_WATERMARK_LEVEL,
    input  wire [9:0]         I_BATCH_THRESHOLD,
    input  wire               I_BATCH_TICK,
    input  wire               I_SAMPLE_TICK,
    // oscillator trim, signed
    input  wire signed [7:0]  I_OSC_TRIM_FINE,
    // event detectors and their status-register reads
    input  wire [EVENTS-1:0]  I_EVENT,
    input  wire [EVENTS-1:0]  I_EVENT_STATUS_RD,
    // sleep state and its routing
    input  wire               I_SLEEP_STATE,
    input  wire               I_IRQ1_SLEEP_ROUTE,
    input  wire               I_IRQ2_SLEEP_ROUTE,
    // interrupt and control outputs
    output reg  [EVENTS-1:0]  O_EVENT_IRQ,
    output reg                O_IRQ1_SLEEP,
    output reg                O_IRQ2_SLEEP,
    output reg                O_MOTION_FILTER_SELECT,
    output reg                O_FUNCS_ENABLE,
    output reg                O_XL_LOW_RATE,
    output reg                O_GYRO_SLEEP,
    output reg                O_GYRO_POWER_DOWN
  );

  // address decode, used for reads and writes alike
  function is_addr;
    input [7:0] a;
    input [7:0] b;
    begin
      is_addr = (a == b);
    end
  endfunction


  // configuration registers

  reg  [7:0] irq_config_first;   // latch, clear-on-read, sleep level, filter
  reg  [7:0] irq_config_second;  // function enable, inactivity mode

  wire clr_on_read = irq_config_first[`CFG1_CLR_ON_READ];
  wire sleep_level = irq_config_first[`CFG1_SLEEP_LEVEL];
  wire latch_mode  = irq_config_first[`CFG1_LATCH_MODE];
  wire funcs_on    = irq_config_second[`CFG2_FUNC_ENABLE];
  wire [1:0] inactivity_mode = {irq_config_second[`CFG2_INACT_HI],
                                irq_config_second[`CFG2_INACT_LO]};

  // writes only reach the two config registers; reserved bits are masked
  // so a careless host cannot leave junk that reads back
  always @(posedge I_CLK_SYS)
  begin
    if (!I_RST_B)
    begin
      irq_config_first  <= `CFG1_RESET;
      irq_config_second <= `CFG2_RESET;
    end
    else if (I_REG_WR)
    begin
      if (is_addr(I_REG_ADDR, `ADDR_IRQ_CONFIG1))
        irq_config_first <= I_REG_WDATA & `CFG1_WMASK;
      if (is_addr(I_REG_ADDR, `ADDR_IRQ_CONFIG2))
        irq_config_second <= I_REG_WDATA & `CFG2_WMASK;
      // status and timestamp addresses fall through untouched
    end
  end


  // fifo status flags

  localparam [9:0] DEPTH_W    = FIFO_DEPTH[9:0];
  localparam [9:0] NEAR_LEVEL = FIFO_DEPTH[9:0] - SAMPLE_ENTRIES[9:0];

  reg       fifo_level_mark_flag;   // fill at or above watermark
  reg       fifo_overrun_flag;      // fifo completely filled
  reg       fifo_nearly_full_flag;  // full after the next sample
  reg       batch_count_flag;       // batch threshold reached
  reg       sticky_overrun_flag;    // overrun seen since last read
  reg [9:0] unread_entry_count;     // entries of tag plus six bytes

  // host reads of the second status register clear the read-cleared flags
  wire rd_status2 = I_REG_RD & is_addr(I_REG_ADDR, `ADDR_FIFO_STATUS_SECOND);

  // live flags sampled together each cycle so they always agree
  always @(posedge I_CLK_SYS)
  begin
    if (!I_RST_B)
    begin
      fifo_level_mark_flag  <= 1'b0;
      fifo_overrun_flag     <= 1'b0;
      fifo_nearly_full_flag <= 1'b0;
      unread_entry_count    <= 10'h000;
    end
    else
    begin
      fifo_level_mark_flag  <= (I_FIFO_LEVEL >= {1'b0, I_WATERMARK_LEVEL});
      fifo_overrun_flag     <= (I_FIFO_LEVEL >= DEPTH_W);
      // one sample more would fill it, but it is not full yet
      fifo_nearly_full_flag <= (I_FIFO_LEVEL >= NEAR_LEVEL) &&
                               (I_FIFO_LEVEL < DEPTH_W);
      unread_entry_count    <= I_FIFO_LEVEL;
    end
  end

  // sticky overrun: a new overrun in the read cycle wins over the clear
  always @(posedge I_CLK_SYS)
  begin
    if (!I_RST_B)
      sticky_overrun_flag <= 1'b0;
    else if (fifo_overrun_flag)
      sticky_overrun_flag <= 1'b1;
    else if (rd_status2)
      sticky_overrun_flag <= 1'b0;
  end

  // batch counter counts batch ticks up to the programmed threshold
  reg  [9:0] batch_count;  // ticks since the last threshold hit
  wire       batch_hit = I_BATCH_TICK && (I_BATCH_THRESHOLD != 10'h000) &&
                         (batch_count + 10'h001 >= I_BATCH_THRESHOLD);

  always @(posedge I_CLK_SYS)
  begin
    if (!I_RST_B)
    begin
      batch_count      <= 10'h000;
      batch_count_flag <= 1'b0;
    end
    else
    begin
      if (batch_hit)
        batch_count <= 10'h000;
      else if (I_BATCH_TICK)
        batch_count <= batch_count + 10'h001;
      // set wins over the read clear
      if (batch_hit)
        batch_count_flag <= 1'b1;
      else if (rd_status2)
        batch_count_flag <= 1'b0;
    end
  end

  // live image of the second status register
  wire [7:0] status2_live = {fifo_level_mark_flag, fifo_overrun_flag,
                             fifo_nearly_full_flag, batch_count_flag,
                             sticky_overrun_flag, 1'b0,
                             unread_entry_count[9:8]};

  // reading the first status register freezes the second one, so the
  // count split over two bytes comes from one sample
  reg [7:0] status2_snap;  // frozen copy for the following read
  reg       snap_armed;    // the previous read was status one

  always @(posedge I_CLK_SYS)
  begin
    if (!I_RST_B)
    begin
      status2_snap <= `STATUS_RESET;
      snap_armed   <= 1'b0;
    end
    else if (I_REG_RD)
    begin
      if (is_addr(I_REG_ADDR, `ADDR_FIFO_STATUS1))
      begin
        status2_snap <= status2_live;
        snap_armed   <= 1'b1;
      end
      else
        snap_armed <= 1'b0;
    end
  end

  // timestamp with trimmed tick
  // phase accumulator: adds 10000 + 15 * trim per clock and ticks at
  // 1250 * 10000, so the period is 25 us / (1 + 0.0015 * trim); the
  // fraction carries over, so no error builds up between ticks
  localparam [23:0]        MODULUS   = `PHASE_MODULUS;
  localparam [23:0]        BASE_STEP = `TRIM_SCALE;  // step at zero trim
  localparam signed [15:0] TRIM_MUL  = `TRIM_STEP;   // step per trim count

  reg  [23:0]        phase;        // fractional tick phase
  reg  [31:0]        time_count;   // 32-bit timestamp
  wire signed [15:0] trim_step = TRIM_MUL * I_OSC_TRIM_FINE;
  wire [23:0]        phase_step = BASE_STEP + {{8{trim_step[15]}}, trim_step};
  wire [23:0]        phase_sum  = phase + phase_step;
  wire               tick_due   = (phase_sum >= MODULUS);

  always @(posedge I_CLK_SYS)
  begin
    if (!I_RST_B)
    begin
      phase      <= 24'h000000;
      time_count <= 32'h00000000;
    end
    else
    begin
      if (tick_due)
      begin
        phase      <= phase_sum - MODULUS;
        time_count <= time_count + 32'h00000001;
      end
      else
        phase <= phase_sum;
    end
  end

  // read of the low byte freezes the whole word for bytes one to three
  wire       rd_time0  = I_REG_RD & is_addr(I_REG_ADDR, `ADDR_TIME_BYTE0);
  wire       rd_timehi = I_REG_RD & (is_addr(I_REG_ADDR, `ADDR_TIME_BYTE1) |
                                     is_addr(I_REG_ADDR, `ADDR_TIME_BYTE2) |
                                     is_addr(I_REG_ADDR, `ADDR_TIME_BYTE3));
  wire [7:0] snap_byte;  // registered byte from the snapshot memory

  time_snap_mem
    #(.BYTES (4))
  u_time_snap
  (
    .clk   (I_CLK_SYS),
    .rst_b (I_RST_B),
    .load  (rd_time0),
    .word  (time_count),
    .rd    (rd_timehi),
    .sel   (I_REG_ADDR[1:0]),
    .rdata (snap_byte)
  );


  // read path: stage one picks a register, stage two drives the port

  reg [7:0] rd_stage;      // data chosen in the access cycle
  reg       rd_from_snap;  // stage two takes the memory byte
  reg       rd_pending;    // a read is in flight
  reg [7:0] next_rd_stage; // combinational selection

  always @*
  begin
    next_rd_stage = 8'h00;  // unmapped addresses read as zero
    case (I_REG_ADDR)
      `ADDR_FIFO_STATUS1: next_rd_stage = unread_entry_count[7:0];
      `ADDR_FIFO_STATUS_SECOND: next_rd_stage = snap_armed ? status2_snap
                                                     : status2_live;
      `ADDR_IRQ_CONFIG1:  next_rd_stage = irq_config_first;
      `ADDR_IRQ_CONFIG2:  next_rd_stage = irq_config_second;
      `ADDR_TIME_BYTE0:   next_rd_stage = time_count[7:0];
      default:            next_rd_stage = 8'h00;
    endcase
  end

  always @(posedge I_CLK_SYS)
  begin
    if (!I_RST_B)
    begin
      rd_stage     <= 8'h00;
      rd_from_snap <= 1'b0;
      rd_pending   <= 1'b0;
      O_REG_RDATA  <= 8'h00;
      O_REG_RVALID <= 1'b0;
    end
    else
    begin
      rd_pending   <= I_REG_RD;
      rd_from_snap <= rd_timehi;
      if (I_REG_RD)
        rd_stage <= next_rd_stage;
      O_REG_RVALID <= rd_pending;
      if (rd_pending)
        O_REG_RDATA <= rd_from_snap ? snap_byte : rd_stage;
    end
  end


  // event interrupt requests

  // with latching off the request follows the event; with it on the
  // request holds until its status is read if clear-upon-read is set, else until the sample period ends
  // (the host must set latching with clear-upon-read)
  reg [EVENTS-1:0] held;  // latched requests

  genvar e;
  generate
    for (e = 0; e < EVENTS; e = e + 1)
    begin : gen_event
      wire ev_in   = I_EVENT[e] & funcs_on;
      wire release_now = clr_on_read ? I_EVENT_STATUS_RD[e]
                                     : I_SAMPLE_TICK;
      always @(posedge I_CLK_SYS)
      begin
        if (!I_RST_B)
          held[e] <= 1'b0;
        else if (!latch_mode)
          held[e] <= 1'b0;
        else if (ev_in)
          held[e] <= 1'b1;  // set wins over release
        else if (release_now)
          held[e] <= 1'b0;
      end
      always @(posedge I_CLK_SYS)
      begin
        if (!I_RST_B)
          O_EVENT_IRQ[e] <= 1'b0;
        else
          O_EVENT_IRQ[e] <= ev_in | (latch_mode & funcs_on & held[e] & ~release_now);
      end
    end
  endgenerate


  // sleep status on the interrupt pins

  reg  sleep_prev;  // sleep state one cycle ago
  wire sleep_change = (I_SLEEP_STATE != sleep_prev);
  wire sleep_sig    = funcs_on & (sleep_level ? I_SLEEP_STATE
                                              : sleep_change);

  always @(posedge I_CLK_SYS)
  begin
    if (!I_RST_B)
    begin
      sleep_prev   <= 1'b0;
      O_IRQ1_SLEEP <= 1'b0;
      O_IRQ2_SLEEP <= 1'b0;
    end
    else
    begin
      sleep_prev   <= I_SLEEP_STATE;
      O_IRQ1_SLEEP <= I_IRQ1_SLEEP_ROUTE & sleep_sig;
      O_IRQ2_SLEEP <= I_IRQ2_SLEEP_ROUTE & sleep_sig;
    end
  end


  // filter choice and power actions

  // each mode from gyro sleep up keeps the low rate of the one below, but the top mode swaps gyro sleep for power-down
  always @(posedge I_CLK_SYS)
  begin
    if (!I_RST_B)
    begin
      O_MOTION_FILTER_SELECT <= 1'b0;
      O_FUNCS_ENABLE         <= 1'b0;
      O_XL_LOW_RATE          <= 1'b0;
      O_GYRO_SLEEP           <= 1'b0;
      O_GYRO_POWER_DOWN      <= 1'b0;
    end
    else
    begin
      O_MOTION_FILTER_SELECT <= irq_config_first[`CFG1_FILTER_SEL];
      O_FUNCS_ENABLE         <= funcs_on;
      case (inactivity_mode)
        `INACT_FLAGS_ONLY:
        begin
          O_XL_LOW_RATE     <= 1'b0;
          O_GYRO_SLEEP      <= 1'b0;
          O_GYRO_POWER_DOWN <= 1'b0;
        end
        `INACT_XL_LOW:
        begin
          O_XL_LOW_RATE     <= 1'b1;
          O_GYRO_SLEEP      <= 1'b0;
          O_GYRO_POWER_DOWN <= 1'b0;
        end
        `INACT_GYRO_SLEEP:
        begin
          O_XL_LOW_RATE     <= 1'b1;
          O_GYRO_SLEEP      <= 1'b1;
          O_GYRO_POWER_DOWN <= 1'b0;
        end
        default:
        begin
          O_XL_LOW_RATE     <= 1'b1;
          O_GYRO_SLEEP      <= 1'b0;
          O_GYRO_POWER_DOWN <= 1'b1;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

// ---- hw/sensor_status_consts.vh ----
// constants for the fifo status, timestamp and interrupt configuration slice
// assumes a 50 MHz system clock and an 8-bit host register port
`ifndef SENSOR_STATUS_CONSTS_VH
`define SENSOR_STATUS_CONSTS_VH

// register offsets on the host register port
`define ADDR_FIFO_STATUS1     8'h3a
`define ADDR_FIFO_STATUS_SECOND     8'h3b
`define ADDR_IRQ_CONFIG1      8'h56
`define ADDR_IRQ_CONFIG2      8'h58
`define ADDR_TIME_BYTE0       8'h40
`define ADDR_TIME_BYTE1       8'h41
`define ADDR_TIME_BYTE2       8'h42
`define ADDR_TIME_BYTE3       8'h43

// fifo_status_second field positions
`define ST2_LEVEL_MARK        7
`define ST2_OVERRUN           6
`define ST2_NEARLY_FULL       5
`define ST2_BATCH             4
`define ST2_STICKY_OVR        3

// irq_config_first field positions
`define CFG1_CLR_ON_READ      6
`define CFG1_SLEEP_LEVEL      5
`define CFG1_FILTER_SEL       4
`define CFG1_LATCH_MODE       0
// irq_config_second field positions
`define CFG2_FUNC_ENABLE      7
`define CFG2_INACT_HI         6
`define CFG2_INACT_LO         5

// writable bit masks, reserved bits store nothing and read zero
`define CFG1_WMASK            8'h71
`define CFG2_WMASK            8'he0
// reset values
`define CFG1_RESET            8'h00
`define CFG2_RESET            8'h00
`define STATUS_RESET          8'h00

// inactivity mode codes
`define INACT_FLAGS_ONLY      2'b00
`define INACT_XL_LOW          2'b01
`define INACT_GYRO_SLEEP      2'b10
`define INACT_GYRO_OFF        2'b11

// timestamp timing: 25 us nominal tick, 20 ns clock
`define CLK_PERIOD_NS         20
`define TICK_NS               25000
`define TICK_CYCLES           (`TICK_NS / `CLK_PERIOD_NS)
// trim scaling: 0.0015 per trim step expressed as 15 per 10000
`define TRIM_SCALE            10000
`define TRIM_STEP             15
`define PHASE_MODULUS         (`TICK_CYCLES * `TRIM_SCALE)

`endif

// ---- hw/time_snap_mem.v ----
// small byte-read memory holding a frozen copy of the timestamp word
// assumes the whole word is loaded at once and bytes are read one at a time
`default_nettype none

module time_snap_mem
  #(parameter BYTES = 4)
  (
    // clock and synchronous active-low reset
    input  wire       clk,
    input  wire       rst_b,
    // load port: whole word in one cycle
    input  wire       load,
    input  wire [8*BYTES-1:0] word,
    // read port: byte select, registered data
    input  wire       rd,
    input  wire [1:0] sel,
    output reg  [7:0] rdata
  );

  reg [7:0] mem [0:BYTES-1];  // snapshot bytes, index 0 is the low byte

  // load every byte together so a read never mixes two counts
  genvar g;
  generate
    for (g = 0; g < BYTES; g = g + 1)
    begin : gen_byte
      always @(posedge clk)
      begin
        if (!rst_b)
          mem[g] <= 8'h00;
        else if (load)
          mem[g] <= word[8*g +: 8];
      end
    end
  endgenerate

  // registered read data
  always @(posedge clk)
  begin
    if (!rst_b)
      rdata <= 8'h00;
    else if (rd)
      rdata <= mem[sel];
  end

endmodule

`default_nettype wire

// ---- verification/fifo_status_props.sv ----
// checker for the fifo status, timestamp and irq configuration slice
// assumes it is bound to the top module and sees only its ports
`default_nettype none
`include "sensor_status_consts.vh"
module fifo_status_props
  #(parameter EVENTS = 4)
  (
    // clock, reset and host port
    input wire logic              I_CLK_SYS,
    input wire logic              I_RST_B,
    input wire logic [7:0]        I_REG_ADDR,
    input wire logic              I_REG_WR,
    input wire logic [7:0]        I_REG_WDATA,
    input wire logic              I_REG_RD,
    input wire logic [7:0]        O_REG_RDATA,
    input wire logic              O_REG_RVALID,
    // events and their clearing causes
    input wire logic              I_SAMPLE_TICK,
    input wire logic [EVENTS-1:0] I_EVENT,
    input wire logic [EVENTS-1:0] I_EVENT_STATUS_RD,
    input wire logic [EVENTS-1:0] O_EVENT_IRQ,
    // control outputs
    input wire logic              O_MOTION_FILTER_SELECT,
    input wire logic              O_FUNCS_ENABLE,
    input wire logic              O_XL_LOW_RATE,
    input wire logic              O_GYRO_SLEEP,
    input wire logic              O_GYRO_POWER_DOWN
  );
  default clocking cb @(posedge I_CLK_SYS);
  endclocking
  default disable iff (!I_RST_B);
  logic [7:0] cfg1;  // mirror of irq_config_first
  logic [7:0] cfg2;  // mirror of irq_config_second
  wire logic  wr1 = I_REG_WR && I_REG_ADDR == `ADDR_IRQ_CONFIG1;
  wire logic  wr2 = I_REG_WR && I_REG_ADDR == `ADDR_IRQ_CONFIG2;
  // quiet: no config write can shift the relation in this cycle
  wire logic  quiet = !I_REG_WR && cfg2[`CFG2_FUNC_ENABLE];
  wire logic  unmapped = !(I_REG_ADDR inside {8'h3a, 8'h3b, 8'h56, 8'h58, [8'h40:8'h43]});
  // mirrors follow host writes the same edge the block takes them
  always_ff @(posedge I_CLK_SYS)
    if (!I_RST_B)
      cfg1 <= 8'h00;
    else if (wr1)
      cfg1 <= I_REG_WDATA & `CFG1_WMASK;
  always_ff @(posedge I_CLK_SYS)
    if (!I_RST_B)
      cfg2 <= 8'h00;
    else if (wr2)
      cfg2 <= I_REG_WDATA & `CFG2_WMASK;
  a_read_answer: assert property (I_REG_RD |-> ##2 O_REG_RVALID)
    else $error("read answer missing two cycles after strobe");
  a_answer_cause: assert property (O_REG_RVALID |-> $past(I_REG_RD, 2))
    else $error("read answer without a read strobe");
  a_unmapped_zero: assert property (I_REG_RD && unmapped |-> ##2 O_REG_RDATA == 8'h00)
    else $error("unmapped read returned nonzero");
  a_filter_follow: assert property (wr1 |-> ##2 O_MOTION_FILTER_SELECT ==
    $past(I_REG_WDATA[`CFG1_FILTER_SEL], 2)) else $error("filter select wrong");
  a_inact_decode: assert property (wr2 |-> ##2 {O_XL_LOW_RATE, O_GYRO_SLEEP,
    O_GYRO_POWER_DOWN} == {$past(I_REG_WDATA[6:5], 2) != 2'b00,
    $past(I_REG_WDATA[6:5], 2) == 2'b10, $past(I_REG_WDATA[6:5], 2) == 2'b11})
    else $error("inactivity decode wrong");
  a_enable_copy: assert property (wr2 |-> ##2 O_FUNCS_ENABLE == $past(I_REG_WDATA[7], 2))
    else $error("enable output wrong");
  a_gate_off: assert property (!cfg2[7] && !I_REG_WR |=> O_EVENT_IRQ == '0)
    else $error("event request while functions disabled");
  a_irq_follow: assert property (quiet && !cfg1[0] |=> O_EVENT_IRQ == $past(I_EVENT))
    else $error("unlatched request does not follow event");
  a_irq_hold: assert property (quiet && cfg1[0] && O_EVENT_IRQ[0] && !I_SAMPLE_TICK
    && !I_EVENT_STATUS_RD[0] |=> O_EVENT_IRQ[0]) else $error("latched request dropped");
  a_clear_read: assert property (quiet && cfg1[0] && cfg1[6] && I_EVENT_STATUS_RD[0]
    && !I_EVENT[0] |=> !O_EVENT_IRQ[0]) else $error("status read did not clear");
  a_clear_period: assert property (quiet && cfg1[0] && !cfg1[6] && I_SAMPLE_TICK
    && !I_EVENT[0] |=> !O_EVENT_IRQ[0]) else $error("period end did not clear");
endmodule
bind fifo_status_timestamp_irq_cfg fifo_status_props #(.EVENTS(EVENTS)) u_props (.*);
`default_nettype wire

// ---- verification/host_port_model.sv ----
// host processor model: one-cycle read and write strobes on the register port
// assumes the block answers each read with a one-cycle valid pulse
`default_nettype none
`include "sensor_status_consts.vh"
module host_port_model
  (
    // clock and answer from the block
    input  wire logic       clk,
    input  wire logic       rvalid,
    input  wire logic [7:0] rdata,
    // request side
    output var logic [7:0]  addr,
    output var logic        wr,
    output var logic [7:0]  wdata,
    output var logic        rd
  );
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    addr = 8'h00;
    wr = 1'b0;
    wdata = 8'h00;
    rd = 1'b0;
  end
  // write one byte; released lines show the inverse so stale values never pass
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    if (a == `ADDR_IRQ_CONFIG1 && d[6])
      d[0] = 1'b1;
    if (a == `ADDR_IRQ_CONFIG1)
      d = d & `CFG1_WMASK;
    if (a == `ADDR_IRQ_CONFIG2)
      d = d & `CFG2_WMASK;
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(posedge clk);
    #1 wr = 1'b0;
    addr = ~a;
    wdata = ~d;
    // spare cycle so a following strobe is never set in the same step
    @(posedge clk);
    #1;
  endtask
  // read one byte, bounded wait for the answer
  task automatic read(input logic [7:0] a, output logic [7:0] d, output logic ok);
    ok = 1'b0;
    d = 8'h00;
    addr = a;
    rd = 1'b1;
    @(posedge clk);
    #1 rd = 1'b0;
    addr = ~a;
    for (int i = 0; i < 4 && !ok; i++)
    begin
      @(posedge clk);
      #1;
      if (rvalid === 1'b1)
      begin
        d = rdata;
        ok = 1'b1;
      end
    end
  endtask
endmodule
`default_nettype wire

// ---- verification/fifo_status_timestamp_irq_cfg_tb.sv ----
// testbench for the fifo status, timestamp and irq configuration slice
// assumes the host model drives the register port and the bench the rest
`default_nettype none
`include "sensor_status_consts.vh"
module fifo_status_timestamp_irq_cfg_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DEPTH = 438;  // fifo entries
  logic clk = 1'b0, rst_b = 1'b0, btick = 1'b0, stick = 1'b0, e0 = 1'b0, erd = 1'b0;
  logic slp = 1'b0, r1 = 1'b0;
  logic [9:0] level = 10'h000, bthr = 10'h003;
  logic signed [7:0] trim = 8'sh00;
  wire logic [7:0] addr, wdata, rdata;
  wire logic wr, rd, rvalid, s1, s2, filt, fen, xl, gs, gpd;
  wire logic [3:0] irq;
  int num_errors = 0, comparisons = 0, cnt = 0, n;
  logic [7:0] d, md [3] = '{8'h00, 8'h01, 8'h41};
  logic [9:0] lv [5] = '{10'h0ff, 10'h100, 10'h101, 10'h1b5, 10'h1b6};
  logic ok;
  logic [31:0] t0, t1;
  always #10 clk = ~clk;
  always @(posedge clk) cnt <= cnt + 1;
  host_port_model host (.clk(clk), .rvalid(rvalid), .rdata(rdata), .addr(addr), .wr(wr),
    .wdata(wdata), .rd(rd));
  fifo_status_timestamp_irq_cfg #(.FIFO_DEPTH(DEPTH)) dut (.I_CLK_SYS(clk), .I_RST_B(rst_b),
    .I_REG_ADDR(addr), .I_REG_WR(wr), .I_REG_WDATA(wdata), .I_REG_RD(rd), .O_REG_RDATA(rdata),
    .O_REG_RVALID(rvalid), .I_FIFO_LEVEL(level), .I_WATERMARK_LEVEL(9'h100),
    .I_BATCH_THRESHOLD(bthr), .I_BATCH_TICK(btick), .I_SAMPLE_TICK(stick),
    .I_OSC_TRIM_FINE(trim), .I_EVENT({3'b000, e0}), .I_EVENT_STATUS_RD({3'b000, erd}),
    .I_SLEEP_STATE(slp), .I_IRQ1_SLEEP_ROUTE(r1), .I_IRQ2_SLEEP_ROUTE(1'b0), .O_EVENT_IRQ(irq),
    .O_IRQ1_SLEEP(s1), .O_IRQ2_SLEEP(s2), .O_MOTION_FILTER_SELECT(filt), .O_FUNCS_ENABLE(fen),
    .O_XL_LOW_RATE(xl), .O_GYRO_SLEEP(gs), .O_GYRO_POWER_DOWN(gpd));
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
    cyc(1);
  endtask
  // read and compare under a mask; a lost answer ends the run
  task automatic rdc(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m = 8'hff);
    host.read(a, d, ok);
    if (!ok)
    begin
      num_errors++;
      report_and_stop();
    end
    chk(d & m, e & m);
  endtask
  // expected status byte; the watermark input is tied at 0x100
  function automatic logic [7:0] stat(input logic [9:0] l, input logic b, input logic s);
    return {l >= 10'h100, l >= DEPTH, l == DEPTH - 1, b, s, 1'b0, l[9:8]};
  endfunction
  // timestamp delta over 12500 cycles, reads low byte first to freeze the word
  task automatic span(output logic [31:0] dt);
    n = cnt;
    for (int k = 0; k < 2; k++)
    begin
      for (int i = 0; i < 4; i++)
      begin
        rdc(`ADDR_TIME_BYTE0 + i[7:0], 8'h00, 8'h00);
        t1[8*i +: 8] = d;
      end
      if (k == 0)
        t0 = t1;
      while (cnt < n + 12500)
        cyc(1);
    end
    dt = t1 - t0;
  endtask
  initial
  begin
    cyc(8);
    rst_b = 1'b1;
    rdc(`ADDR_FIFO_STATUS_SECOND, `STATUS_RESET);
    rdc(`ADDR_IRQ_CONFIG1, `CFG1_RESET);
    rdc(`ADDR_IRQ_CONFIG2, `CFG2_RESET);
    rdc(8'h10, 8'h00);
    host.write(`ADDR_FIFO_STATUS_SECOND, 8'hff);
    host.write(`ADDR_TIME_BYTE3, 8'hff);
    rdc(`ADDR_FIFO_STATUS_SECOND, 8'h00);
    rdc(`ADDR_TIME_BYTE3, 8'h00);
    $display("done: reset and read-only");
    // level changes after the low-count read; the status read must match it
    foreach (lv[i])
    begin
      level = lv[i];
      cyc(3);
      rdc(`ADDR_FIFO_STATUS1, lv[i][7:0]);
      level = 10'h000;
      cyc(2);
      rdc(`ADDR_FIFO_STATUS_SECOND, stat(lv[i], 1'b0, 1'b0), 8'hf7);
    end
    level = DEPTH;
    cyc(3);
    level = 10'h000;
    cyc(3);
    for (int i = 0; i < 2; i++)
    begin
      rdc(`ADDR_FIFO_STATUS1, 8'h00);
      rdc(`ADDR_FIFO_STATUS_SECOND, {4'h0, i == 0, 3'b000});
    end
    $display("done: fifo flags");
    repeat (2) pulse(btick);
    rdc(`ADDR_FIFO_STATUS1, 8'h00);
    rdc(`ADDR_FIFO_STATUS_SECOND, 8'h00);
    pulse(btick);
    for (int i = 0; i < 2; i++)
    begin
      rdc(`ADDR_FIFO_STATUS1, 8'h00);
      rdc(`ADDR_FIFO_STATUS_SECOND, {3'b000, i == 0, 4'h0});
    end
    $display("done: batch flag");
    span(t0);
    chk(t0, 12500 * `TRIM_SCALE / `PHASE_MODULUS);
    trim = 8'sd100;
    span(t0);
    chk(t0 - 12500 * (`TRIM_SCALE + `TRIM_STEP * 100) / `PHASE_MODULUS <= 1, 1);
    $display("done: timestamp");
    for (int i = 0; i < 4; i++)
    begin
      host.write(`ADDR_IRQ_CONFIG2, {i[0], i[1:0], 5'h1f});
      host.write(`ADDR_IRQ_CONFIG1, {3'b000, i[0], 4'hf});
      rdc(`ADDR_IRQ_CONFIG2, {i[0], i[1:0], 5'h00});
      rdc(`ADDR_IRQ_CONFIG1, {3'b000, i[0], 4'h1});
      chk({xl, gs, gpd}, {i[1:0] != 0, i[1:0] == 2, i[1:0] == 3});
      chk({fen, filt}, {i[0], i[0]});
    end
    $display("done: configuration");
    host.write(`ADDR_IRQ_CONFIG2, 8'h80);
    foreach (md[k])
    begin
      host.write(`ADDR_IRQ_CONFIG1, md[k]);
      pulse(e0);
      chk(irq[0], md[k][0]);
      pulse(stick);
      chk(irq[0], md[k][6]);
      pulse(erd);
      chk(irq[0], 1'b0);
    end
    host.write(`ADDR_IRQ_CONFIG2, 8'h00);
    e0 = 1'b1;
    cyc(3);
    chk(irq[0], 1'b0);
    e0 = 1'b0;
    $display("done: event requests");
    host.write(`ADDR_IRQ_CONFIG2, 8'h80);
    host.write(`ADDR_IRQ_CONFIG1, 8'h00);
    r1 = 1'b1;
    slp = 1'b1;
    n = 0;
    repeat (6)
    begin
      cyc(1);
      n = n + s1 + 16 * s2;
    end
    chk(n, 1);
    host.write(`ADDR_IRQ_CONFIG1, 8'h20);
    cyc(2);
    chk(s1, 1'b1);
    slp = 1'b0;
    cyc(2);
    chk(s1, 1'b0);
    $display("done: sleep signalling");
    report_and_stop();
  end
endmodule
`default_nettype wire
